// ===== hdl/qdc_dac.sv
`timescale 1ns/1ps
module qdc_dac
  import qdc_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  qdc_link_if.dac                    link,
  output logic [NUM_CHAN*WORD_BITS-1:0] out_word_o,
  output logic [NUM_CHAN-1:0]        out_enable_o,
  output logic [NUM_CHAN-1:0]        pending_o
);

  // ==========================================================================
  // Pin synchronisers: two flip-flops per pin, reset to the pin's idle level.
  localparam int unsigned NUM_PINS = 5;

  logic [NUM_PINS-1:0] raw;
  logic [NUM_PINS-1:0] pin_sync;
  assign raw = {link.sclk, link.sync_n, link.din, link.load_strobe_n, link.power_down_n};

  genvar pin;
  generate
    for (pin = 0; pin < NUM_PINS; pin++) begin : g_sync
      logic a_q;
      logic a_d;
      logic b_q;
      logic b_d;

      always_comb begin
        a_d = raw[pin];
        b_d = a_q;
      end

      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          a_q <= PIN_IDLE[pin];
          b_q <= PIN_IDLE[pin];
        end else begin
          a_q <= a_d;
          b_q <= b_d;
        end
      end

      assign pin_sync[pin] = b_q;
    end
  endgenerate

  logic sclk_s;
  logic sync_n_s;
  logic din_s;
  logic load_n_s;
  logic pd_n_s;
  logic sclk_fall;
  assign sclk_s    = pin_sync[4];
  assign sync_n_s  = pin_sync[3];
  assign din_s     = pin_sync[2];
  assign load_n_s  = pin_sync[1];
  assign pd_n_s    = pin_sync[0];

  // The previous level starts at the clock's idle low, so leaving reset shows no false edge.
  logic sclk_prev_q;
  logic sclk_prev_d;

  always_comb begin
    sclk_prev_d = sclk_s;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
    end
  end

  assign sclk_fall = sclk_prev_q & ~sclk_s;

  // ==========================================================================
  // Clear synchroniser: assert asynchronously, release through two stages.
  logic clr_a_q;
  logic clr_a_d;
  logic clr_b_q;
  logic clr_b_d;

  always_comb begin
    clr_a_d = 1'b0;
    clr_b_d = clr_a_q;
  end

  always_ff @(posedge mclk_i or posedge rst_i or negedge link.clear_n) begin
    if (rst_i) begin
      clr_a_q <= 1'b1;
      clr_b_q <= 1'b1;
    end else if (!link.clear_n) begin
      clr_a_q <= 1'b1;
      clr_b_q <= 1'b1;
    end else begin
      clr_a_q <= clr_a_d;
      clr_b_q <= clr_b_d;
    end
  end
  logic zap;
  assign zap = rst_i | clr_b_q;

  // ==========================================================================
  // Shift register and frame counter.
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] shift_d;
  logic [CNT_BITS-1:0]   cnt_q;
  logic [CNT_BITS-1:0]   cnt_d;
  logic                  done_q;
  logic                  done_d;

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    if (sync_n_s) begin
      cnt_d = '0;
    end else if (sclk_fall && cnt_q < CNT_BITS'(FRAME_BITS)) begin
      shift_d = {shift_q[FRAME_BITS-2:0], din_s};
      cnt_d   = cnt_q + 1'b1;
      done_d  = (cnt_q == CNT_BITS'(FRAME_BITS - 1));
    end
  end

  always_ff @(posedge mclk_i or posedge zap) begin
    if (zap) begin
      shift_q <= '0;
      cnt_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
    end
  end

  // ==========================================================================
  // Input, output-code and pending registers per channel.
  logic [CHAN_BITS-1:0] sel;
  logic [WORD_BITS-1:0] new_word;
  assign sel      = {shift_q[CHAN_HI_POS], shift_q[CHAN_LO_POS]};
  assign new_word = {shift_q[GAIN_POS], shift_q[REFBUF_POS], shift_q[CODE_BITS-1:0]};

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_ch
      logic [WORD_BITS-1:0] in_q;
      logic [WORD_BITS-1:0] in_d;
      logic [WORD_BITS-1:0] dac_q;
      logic [WORD_BITS-1:0] dac_d;
      logic                 pend_q;
      logic                 pend_d;
      logic                 wr;

      always_comb begin
        wr     = done_q && (sel == CHAN_BITS'(ch));
        in_d   = in_q;
        dac_d  = dac_q;
        pend_d = pend_q;
        if (wr) begin
          in_d   = new_word;
          pend_d = 1'b1;
        end
        if (!load_n_s && pend_d) begin
          dac_d  = in_d;
          pend_d = 1'b0;
        end
      end

      always_ff @(posedge mclk_i or posedge zap) begin
        if (zap) begin
          in_q   <= WORD_RESET;
          dac_q  <= WORD_RESET;
          pend_q <= 1'b0;
        end else begin
          in_q   <= in_d;
          dac_q  <= dac_d;
          pend_q <= pend_d;
        end
      end

      assign out_word_o[ch*WORD_BITS +: WORD_BITS] = dac_q;
      assign out_enable_o[ch] = pd_n_s;
      assign pending_o[ch]    = pend_q;
    end
  endgenerate

endmodule : qdc_dac

// ===== hdl/qdc_host.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module qdc_host
  import qdc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  qdc_link_if.host         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOW  = 4'h2,
    ST_HIGH = 4'h4,
    ST_END  = 4'h8
  } qdc_state_e;

  // ==========================================================================
  // AXI4-Lite slave and control registers.
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic        go_q;
  logic        go_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic        busy;
  logic        wr_fire;
  logic        rd_fire;
  logic        start;

  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    ctrl_d   = ctrl_q;
    word_d   = word_q;
    go_d     = go_q & ~start;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (s_axi_awaddr == REG_DATA) begin
        if (!busy && !go_q) begin
          word_d = s_axi_wdata[15:0];
          go_d   = 1'b1;
        end else begin
          bresp_d = RESP_SLVERR;
        end
      end else if (s_axi_awaddr == REG_CTRL) begin
        if (s_axi_wstrb[0]) begin
          ctrl_d[7:0] = s_axi_wdata[7:0];
        end
      end else if (s_axi_awaddr != REG_STATUS) begin
        bresp_d = RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      if (s_axi_araddr == REG_DATA) begin
        rdata_d = {16'h0000, word_q};
      end else if (s_axi_araddr == REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_d = {31'h0000_0000, busy | go_q};
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q   <= CTRL_RESET;
      word_q   <= 16'h0000;
      go_q     <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else begin
      ctrl_q   <= ctrl_d;
      word_q   <= word_d;
      go_q     <= go_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ==========================================================================
  // Serial frame engine.
  qdc_state_e            st_q;
  qdc_state_e            st_d;
  logic [DIV_BITS-1:0]   div_q;
  logic [DIV_BITS-1:0]   div_d;
  logic [CNT_BITS-1:0]   bit_q;
  logic [CNT_BITS-1:0]   bit_d;
  logic [FRAME_BITS-1:0] sh_q;
  logic [FRAME_BITS-1:0] sh_d;
  logic                  tick;
  logic [FRAME_BITS-1:0] ordered;

  assign start = go_q && (st_q == ST_IDLE);
  assign busy  = (st_q != ST_IDLE);
  assign tick  = (div_q == DIV_BITS'(SCLK_HALF_CYC - 1));

  always_comb begin
    ordered = word_q;
    if (ctrl_q[CTRL_LSB_POS]) begin
      for (int i = 0; i < FRAME_BITS; i++) begin
        ordered[i] = word_q[(i & ~7) + 7 - (i & 7)];
      end
    end
  end

  always_comb begin
    st_d  = st_q;
    div_d = tick ? '0 : div_q + 1'b1;
    bit_d = bit_q;
    sh_d  = sh_q;
    case (st_q)
      ST_IDLE: begin
        div_d = '0;
        if (start) begin
          sh_d  = ordered;
          bit_d = '0;
          st_d  = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tick) begin
          if (bit_q != '0) begin
            sh_d = {sh_q[FRAME_BITS-2:0], 1'b0};
          end
          st_d = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tick) begin
          bit_d = bit_q + 1'b1;
          st_d  = (bit_q == CNT_BITS'(FRAME_BITS - 1)) ? ST_END : ST_LOW;
        end
      end
      ST_END: begin
        if (tick) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= ST_IDLE;
      div_q <= '0;
      bit_q <= '0;
      sh_q  <= '0;
    end else begin
      st_q  <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
    end
  end

  // ==========================================================================
  // Pin registers.
  logic sclk_q;
  logic sync_q;
  logic din_q;
  logic load_q;
  logic pd_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
      din_q  <= 1'b0;
      load_q <= 1'b1;
      pd_q   <= 1'b1;
    end else begin
      sclk_q <= (st_d == ST_HIGH) ^ ctrl_q[CTRL_BYTE_POS];
      sync_q <= (st_d == ST_IDLE);
      din_q  <= sh_d[FRAME_BITS-1];
      load_q <= ctrl_q[CTRL_LOAD_POS];
      pd_q   <= ctrl_q[CTRL_PD_POS];
    end
  end

  assign link.sclk          = sclk_q;
  assign link.sync_n        = sync_q;
  assign link.din           = din_q;
  assign link.load_strobe_n = load_q;
  assign link.power_down_n  = pd_q;
  assign link.clear_n       = ~rst_i;

endmodule : qdc_host

// ===== hdl/qdc_link_if.sv
`timescale 1ns/1ps
interface qdc_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic load_strobe_n;
  logic power_down_n;
  logic clear_n;

  modport host (
    output sclk,
    output sync_n,
    output din,
    output load_strobe_n,
    output power_down_n,
    output clear_n
  );
  modport dac (
    input sclk,
    input sync_n,
    input din,
    input load_strobe_n,
    input power_down_n,
    input clear_n
  );
endinterface : qdc_link_if

// ===== hdl/qdc_pkg.sv
package qdc_pkg;

  // ==========================================================================
  // Frame layout.
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CHAN_HI_POS  = 15;
  localparam int unsigned CHAN_LO_POS  = 14;
  localparam int unsigned GAIN_POS     = 13;
  localparam int unsigned REFBUF_POS   = 12;
  localparam int unsigned CODE_BITS    = 12;
  localparam int unsigned NUM_CHAN     = 4;
  localparam int unsigned CHAN_BITS    = 2;
  localparam int unsigned CNT_BITS     = 5;

  // ==========================================================================
  // Channel word: gain, reference buffer and code travel together.
  localparam int unsigned WORD_BITS    = CODE_BITS + 2;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 14'h0000;

  // ==========================================================================
  // Link clock timing.
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SCLK_PERIOD_NS = 320;
  localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned DIV_BITS       = 4;

  // ==========================================================================
  // Idle pin levels {sclk, sync_n, din, load_strobe_n, power_down_n}.
  localparam logic [4:0] PIN_IDLE = 5'h0b;

  // ==========================================================================
  // Host register map on AXI4-Lite.
  localparam logic [3:0] REG_DATA   = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int unsigned CTRL_LOAD_POS = 0;
  localparam int unsigned CTRL_PD_POS   = 1;
  localparam int unsigned CTRL_LSB_POS  = 2;
  localparam int unsigned CTRL_BYTE_POS = 3;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0003;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : qdc_pkg

// ===== testbench/qdc_link_props.sv
`timescale 1ns/1ps
module qdc_link_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic load_strobe_n,
  input wire logic power_down_n,
  input wire logic clear_n
);
  // ====================
  // Falling serial clock edges counted within the current frame.
  logic       sclk_q;
  logic       sclk_d;
  logic [4:0] falls_q;
  logic [4:0] falls_d;

  always_comb begin
    sclk_d  = sclk;
    falls_d = sync_n ? 5'h00 : falls_q + {4'h0, sclk_q & ~sclk};
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q  <= 1'b0;
      falls_q <= 5'h00;
    end else begin
      sclk_q  <= sclk_d;
      falls_q <= falls_d;
    end
  end

  // ====================
  // Link checks.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_sclk_idle_low: assert property (sync_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_frame_starts_low: assert property ($fell(sync_n) |-> !sclk[*3])
    else $error("serial clock not low at frame start");
  a_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong length");
  a_low_half: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("serial clock low phase too short");
  a_din_stable_high: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("data moved while serial clock high");
  a_clock_in_frame: assert property ($rose(sclk) |-> !sync_n)
    else $error("serial clock rose with frame sync high");
  a_sixteen_falls: assert property ($rose(sync_n) |-> falls_q == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_no_extra_falls: assert property (!sync_n |-> falls_q <= 5'h10)
    else $error("more than sixteen falls in a frame");
  a_frame_min_len: assert property ($fell(sync_n) |-> !sync_n[*8])
    else $error("frame sync released too early");

  cover property ($rose(sync_n));
  cover property (!load_strobe_n && $rose(sync_n));
  cover property ($fell(power_down_n) && clear_n);
endmodule : qdc_link_props

// ===== testbench/tb_quad_dac_double_buffer_ctrl.sv
`timescale 1ns/1ps
module tb_quad_dac_double_buffer_ctrl;
  import qdc_pkg::*;
  // ====================
  logic mclk_i = 1'b0;
  logic rst_i  = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [55:0] out_word_o;
  logic [3:0] out_enable_o, pending_o, pend;
  logic [3:0][13:0] exp_in, exp_out;
  logic [15:0] cap;
  logic sn, pd;
  int nf, n_errors = 0, n_checks = 0;

  always #20 mclk_i = ~mclk_i;

  qdc_link_if link ();
  qdc_host i_qdc_host (.mclk_i, .rst_i, .link(link.host), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  qdc_dac i_qdc_dac (.mclk_i, .rst_i, .link(link.dac), .out_word_o, .out_enable_o, .pending_o);
  qdc_link_props i_qdc_link_props (.mclk_i, .rst_i, .sclk(link.sclk), .sync_n(link.sync_n),
    .din(link.din), .load_strobe_n(link.load_strobe_n), .power_down_n(link.power_down_n),
    .clear_n(link.clear_n));

  // Captures each bit at the falling serial clock edge.
  always @(negedge link.sclk) if (!link.sync_n) begin
    cap = {cap[14:0], link.din};
    nf++;
  end

  // ====================
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    @(posedge mclk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge mclk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w  = s_axi_wvalid & s_axi_wready;
      b  = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar, rv;
    @(posedge mclk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge mclk_i);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk_i);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (rv !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axr

  // Copies pending channels while the strobe is low.
  function automatic void model;
    for (int i = 0; i < 4; i++) if (!sn && pend[i]) begin
      exp_out[i] = exp_in[i];
      pend[i]    = 1'b0;
    end
  endfunction : model

  task automatic setctl(input logic [31:0] v);
    axw(REG_CTRL, v, r);
    chk(r, RESP_OKAY);
    pd = v[1];
    sn = v[0];
    model();
  endtask : setctl

  task automatic send(input logic [1:0] ch, input logic [13:0] w, input logic mid,
                      input logic rev = 1'b0);
    logic [15:0] x;
    logic [15:0] v;
    x = {ch, w};
    v = x;
    if (rev) begin
      for (int i = 0; i < 8; i++) begin
        v[i]     = x[7 - i];
        v[8 + i] = x[15 - i];
      end
    end
    nf = 0;
    axw(REG_DATA, {16'h0, v}, r);
    chk(r, RESP_OKAY);
    if (mid) begin
      axw(REG_DATA, 32'h0000_ffff, r);
      chk(r, RESP_SLVERR);
      setctl(32'h2);
    end
    for (int t = 0; t < 80; t++) begin
      axr(REG_STATUS, d, r);
      if (d[0] === 1'b0) break;
    end
    chk(d[0], 1'b0);
    chk(cap, {ch, w});
    chk(nf, 16);
    exp_in[ch] = w;
    pend[ch]   = 1'b1;
    model();
  endtask : send

  task automatic chk_out;
    for (int t = 0; t < 20; t++) begin
      @(negedge mclk_i);
      if (out_word_o === exp_out && out_enable_o === {4{pd}} && pending_o === pend) break;
    end
    chk(out_word_o, exp_out);
    chk(out_enable_o, {4{pd}});
    chk(pending_o, pend);
  endtask : chk_out

  task automatic clr_model;
    exp_in  = '0;
    exp_out = '0;
    pend    = 4'h0;
    sn      = 1'b1;
    pd      = 1'b1;
  endtask : clr_model

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // ====================
  initial begin
    #1_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    logic [2:0][13:0] tw;
    tw = {14'h3a5c, 14'h1001, 14'h2fff};
    clr_model();
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk_out();
    axr(REG_CTRL, d, r);
    chk(d, CTRL_RESET);
    axr(4'hc, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR});
    for (int i = 0; i < 3; i++) begin
      send(i[1:0], tw[i], 1'b0);
      chk_out();
    end
    send(2'h3, 14'h0c3a, 1'b1);
    chk_out();
    send(2'h1, 14'h2123, 1'b0);
    chk_out();
    setctl(32'h1);
    chk_out();
    send(2'h2, 14'h1456, 1'b0);
    chk_out();
    setctl(32'h0);
    chk_out();
    setctl(32'h3);
    chk_out();
    setctl(32'h7);
    axr(REG_CTRL, d, r);
    chk(d, 32'h0000_0007);
    send(2'h0, 14'h0777, 1'b0, 1'b1);
    chk_out();
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    clr_model();
    chk_out();
    final_report();
  end
endmodule : tb_quad_dac_double_buffer_ctrl
